// [ssl_defs.svh]
/*
 * Constants of the supply status and level register bank:
 * register offsets, field positions, widths, limits and reset values.
 * Assumes it is included by bare name, once per compilation unit.
 */
`ifndef SSL_DEFS_SVH
`define SSL_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SSL_OFF_STATUS     8'h30
`define SSL_OFF_CORE_LVL   8'h34
`define SSL_OFF_PLL_LVL    8'h40

// ----------------------------------------------------------------
// Status register bit positions
// ----------------------------------------------------------------
`define SSL_BIT_OSC_STABLE 24
`define SSL_BIT_PLL_GOOD   19
`define SSL_BIT_CORE_GOOD  16
`define SSL_BIT_ANA_LIMIT  9
`define SSL_BIT_CORE_LIMIT 8
`define SSL_BIT_ANA_SOFT   1
`define SSL_BIT_CORE_SOFT  0

// ----------------------------------------------------------------
// Level fields
// ----------------------------------------------------------------
`define SSL_CORE_W         7
`define SSL_PLL_W          3
`define SSL_CORE_MAX       7'h46
`define SSL_PLL_MAX        3'h7

// ----------------------------------------------------------------
// Bus widths and reset values
// ----------------------------------------------------------------
`define SSL_ADDR_W         8
`define SSL_DATA_RST       32'h0000_0000

`endif

// [ssl_pkg.sv]
/*
 * Types of the supply status and level register bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ssl_pkg;

    // ------------------------------------------------------------
    // Live supply condition, one bit per analog indicator
    // ------------------------------------------------------------
    typedef struct packed {
        logic osc_stable;
        logic pll_supply_rail_good;
        logic core_supply_rail_good;
        logic analog_buck_converter_limit;
        logic core_buck_converter_limit;
        logic analog_buck_converter_soft;
        logic core_buck_converter_soft;
    } ssl_supply_t;

endpackage

// [ssl_sync.sv]
/*
 * Two-flop synchroniser, one chain per bit.
 * Assumes inputs are static or slow compared with the clock; no reset so
 * that strap levels pass through while the block is held in reset.
 */
`timescale 1ns/1ps

module ssl_sync #(
    parameter int W = 1
) (
    // Clock
    input  wire logic         clk,
    // Asynchronous levels and their synchronised copies
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_q;
            logic stab_q;
            always_ff @(posedge clk) begin
                meta_q <= async_in[i];
                stab_q <= meta_q;
            end
            assign sync_out[i] = stab_q;
        end
    endgenerate

endmodule

// [ssl_level.sv]
/*
 * One target level field: loaded from its strap while reset is held,
 * written by software afterwards, codes above the top code clamped.
 * Assumes the strap input is already synchronised to clk.
 */
`timescale 1ns/1ps

module ssl_level #(
    parameter int           W    = 3,
    parameter logic [W-1:0] MAXC = '1
) (
    // Clock and synchronous reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Strap level used as reset value
    input  wire logic [W-1:0] strap,
    // Software write
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_data,
    // Current target level
    output logic      [W-1:0] level_q
);

    logic [W-1:0] level_d;

    always_comb begin
        level_d = (wr_data > MAXC) ? MAXC : wr_data;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            level_q <= strap;              // see R7
        end else if (wr_en) begin
            level_q <= level_d;            // see R5, see R8
        end
    end

endmodule

// [ssl_regs.sv]
/*
 * Supply status and level register bank, APB slave.
 * Holds the live supply status word and the target levels of the core
 * supply rail and of the pll linear regulator.
 * Assumes an APB master on CLK, analog status levels and decoded strap
 * levels that are asynchronous and are synchronised here, and RST held
 * for at least three edges with the straps stable.
 */
// Design decision made here: the APB slave port.
// Contract
// R1: Status bit 24 reads one while the on-die oscillator is stable.
// R2: Status bit 19 shows pll rail good, bit 16 core rail good.
// R3: Status bits 9 and 8 show analog and core buck current limiting.
// R4: Status bits 1 and 0 show analog and core buck soft-start.
// R5: Core level is writable bits 6:0, 0.60V plus 10 mV per code.
// R6: Software moves core level by at most 10 mV per microsecond.
// R7: Both level fields reset to the values given by the strap pins.
// R8: Pll level is writable bits 2:0, 0.6V plus 100 mV per code.
// R9: Software raises pll level one code at a time.
// R10: Status writes and reserved bits are ignored; reserved bits read zero.
`timescale 1ns/1ps
`include "ssl_defs.svh"

module ssl_regs (
    // Clock and reset
    input  wire logic                      CLK,
    input  wire logic                      RST,
    // APB slave
    input  wire logic                      PSEL,
    input  wire logic                      PENABLE,
    input  wire logic                      PWRITE,
    input  wire logic [`SSL_ADDR_W-1:0]    PADDR,
    input  wire logic [31:0]               PWDATA,
    input  wire logic [3:0]                PSTRB,
    output logic      [31:0]               PRDATA,
    output logic                           PREADY,
    output logic                           PSLVERR,
    // Analog supply indicators
    input  wire ssl_pkg::ssl_supply_t      SUPPLY,
    // Strap levels decoded from the mode pins
    input  wire logic [`SSL_CORE_W-1:0]    STRAP_CORE_LEVEL,
    input  wire logic [`SSL_PLL_W-1:0]     STRAP_PLL_LEVEL,
    // Target levels to the regulators
    output logic      [`SSL_CORE_W-1:0]    CORE_LEVEL,
    output logic      [`SSL_PLL_W-1:0]     PLL_LEVEL
);

    import ssl_pkg::*;

    localparam int SYNC_W = $bits(ssl_supply_t) + `SSL_CORE_W + `SSL_PLL_W;

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    logic [SYNC_W-1:0]      sync_out;
    ssl_supply_t            supply_s;
    logic [`SSL_CORE_W-1:0] strap_core_s;
    logic [`SSL_PLL_W-1:0]  strap_pll_s;

    ssl_sync #(
        .W (SYNC_W)
    ) u_sync (
        .clk      (CLK),
        .async_in ({SUPPLY, STRAP_CORE_LEVEL, STRAP_PLL_LEVEL}),
        .sync_out (sync_out)
    );

    assign {supply_s, strap_core_s, strap_pll_s} = sync_out;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic hit_status;
    logic hit_core;
    logic hit_pll;
    logic unmapped;
    logic setup;
    logic access;

    assign hit_status = (PADDR == `SSL_OFF_STATUS);
    assign hit_core   = (PADDR == `SSL_OFF_CORE_LVL);
    assign hit_pll    = (PADDR == `SSL_OFF_PLL_LVL);
    assign unmapped   = ~(hit_status | hit_core | hit_pll);
    assign setup      = PSEL & ~PENABLE;
    assign access     = PSEL & PENABLE & PREADY;

    // ------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------
    logic [31:0] status_word;

    always_comb begin
        status_word = `SSL_DATA_RST;       // see R10
        status_word[`SSL_BIT_OSC_STABLE] = supply_s.osc_stable;  // see R1
        status_word[`SSL_BIT_PLL_GOOD]   =
            supply_s.pll_supply_rail_good;                       // see R2
        status_word[`SSL_BIT_CORE_GOOD]  =
            supply_s.core_supply_rail_good;                      // see R2
        status_word[`SSL_BIT_ANA_LIMIT]  =
            supply_s.analog_buck_converter_limit;                // see R3
        status_word[`SSL_BIT_CORE_LIMIT] =
            supply_s.core_buck_converter_limit;                  // see R3
        status_word[`SSL_BIT_ANA_SOFT]   =
            supply_s.analog_buck_converter_soft;                 // see R4
        status_word[`SSL_BIT_CORE_SOFT]  =
            supply_s.core_buck_converter_soft;                   // see R4
    end

    // ------------------------------------------------------------
    // Read data mux
    // ------------------------------------------------------------
    logic [31:0] rdata_d;

    always_comb begin
        rdata_d = `SSL_DATA_RST;
        if (hit_status) begin
            rdata_d = status_word;
        end else if (hit_core) begin
            rdata_d[`SSL_CORE_W-1:0] = CORE_LEVEL;   // see R10
        end else if (hit_pll) begin
            rdata_d[`SSL_PLL_W-1:0] = PLL_LEVEL;     // see R10
        end
    end

    // ------------------------------------------------------------
    // Bus answer: ready in the first access cycle
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            PREADY <= 1'b0;
        end else begin
            PREADY <= setup;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            PSLVERR <= 1'b0;
        end else if (setup) begin
            PSLVERR <= unmapped;
        end else if (access) begin
            PSLVERR <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            PRDATA <= `SSL_DATA_RST;
        end else if (setup) begin
            PRDATA <= PWRITE ? `SSL_DATA_RST : rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Level registers
    // ------------------------------------------------------------
    logic wr_lane0;
    logic wr_core;
    logic wr_pll;

    // Status register has no write path at all
    assign wr_lane0 = access & PWRITE & PSTRB[0];   // see R10
    assign wr_core  = wr_lane0 & hit_core;
    assign wr_pll   = wr_lane0 & hit_pll;

    ssl_level #(
        .W    (`SSL_CORE_W),
        .MAXC (`SSL_CORE_MAX)
    ) u_core_level (
        .clk     (CLK),
        .rst     (RST),
        .strap   (strap_core_s),
        .wr_en   (wr_core),
        .wr_data (PWDATA[`SSL_CORE_W-1:0]),
        .level_q (CORE_LEVEL)
    );

    ssl_level #(
        .W    (`SSL_PLL_W),
        .MAXC (`SSL_PLL_MAX)
    ) u_pll_level (
        .clk     (CLK),
        .rst     (RST),
        .strap   (strap_pll_s),
        .wr_en   (wr_pll),
        .wr_data (PWDATA[`SSL_PLL_W-1:0]),
        .level_q (PLL_LEVEL)
    );

endmodule

// [ssl_regs_sva.sv]
/* Assertions on the ports of ssl_regs, bound into every instance.
   Assumes straps stay stable while RST is high. */
`timescale 1ns/1ps
module ssl_regs_sva import ssl_pkg::*; (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // APB bus
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [31:0] PRDATA,
    input  wire logic [3:0]  PSTRB,
    input  wire logic        PREADY,
    input  wire logic        PSLVERR,
    // Supplies, straps and levels
    input  wire ssl_supply_t SUPPLY,
    input  wire logic [6:0]  STRAP_CORE_LEVEL,
    input  wire logic [6:0]  CORE_LEVEL,
    input  wire logic [2:0]  STRAP_PLL_LEVEL,
    input  wire logic [2:0]  PLL_LEVEL
);
    logic [6:0] sup_q, cw;
    logic [2:0] same_q;
    logic       acc, rd_st;
    assign acc = PSEL && PENABLE && PREADY;
    assign rd_st = acc && !PWRITE && PADDR == 8'h30 && same_q > 3'h4;
    assign cw = (PWDATA[6:0] > 7'h46) ? 7'h46 : PWDATA[6:0];
    // Cycles for which the supply flags have not moved
    always_ff @(posedge CLK) begin
        sup_q <= SUPPLY;
        if (RST || SUPPLY != sup_q)
            same_q <= 3'h0;
        else if (same_q != 3'h7)
            same_q <= same_q + 3'h1;
    end
    // ----------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    chk_osc_flag: assert property (rd_st |-> PRDATA[24] == SUPPLY[6])
        else $error("osc flag wrong");
    chk_good_flags: assert property (rd_st |->
        PRDATA[19] == SUPPLY[5] && PRDATA[16] == SUPPLY[4])
        else $error("good flags wrong");
    chk_limit_flags: assert property (
        rd_st |-> PRDATA[9:8] == SUPPLY[3:2])
        else $error("limit flags wrong");
    chk_soft_flags: assert property (
        rd_st |-> PRDATA[1:0] == SUPPLY[1:0])
        else $error("soft flags wrong");
    chk_status_resv: assert property (
        rd_st |-> (PRDATA & 32'hfef6_fcfc) == 0)
        else $error("status reserved set");
    chk_core_write: assert property (acc && PWRITE && PSTRB[0] &&
        PADDR == 8'h34 |=> CORE_LEVEL == $past(cw))
        else $error("core level write wrong");
    chk_pll_write: assert property (acc && PWRITE && PSTRB[0] &&
        PADDR == 8'h40 |=> PLL_LEVEL == $past(PWDATA[2:0]))
        else $error("pll level write wrong");
    chk_strap_reset: assert property ($fell(RST) |->
        CORE_LEVEL == STRAP_CORE_LEVEL && PLL_LEVEL == STRAP_PLL_LEVEL)
        else $error("strap reset value wrong");
    chk_write_ignored: assert property (acc && PWRITE &&
        (PADDR == 8'h30 || !PSTRB[0]) |=>
        $stable(CORE_LEVEL) && $stable(PLL_LEVEL))
        else $error("ignored write took effect");
    chk_level_read: assert property (acc && !PWRITE && PADDR == 8'h34 |->
        PRDATA == {25'h0, CORE_LEVEL})
        else $error("core readback wrong");
    chk_pll_read: assert property (acc && !PWRITE && PADDR == 8'h40 |->
        PRDATA == {29'h0, PLL_LEVEL})
        else $error("pll readback wrong");
    chk_unmapped_access: assert property (
        acc && !(PADDR inside {8'h30, 8'h34, 8'h40})
        |-> PSLVERR && PRDATA == 0)
        else $error("unmapped access wrong");
    cover property (rd_st && PRDATA[24]);
    cover property (acc && PWRITE && PADDR == 8'h34 && PWDATA[6:0] > 7'h46);
    cover property (acc && PSLVERR);
endmodule
bind ssl_regs ssl_regs_sva ssl_regs_sva_i (.CLK(CLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PSTRB(PSTRB), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SUPPLY(SUPPLY), .STRAP_CORE_LEVEL(STRAP_CORE_LEVEL),
    .CORE_LEVEL(CORE_LEVEL), .STRAP_PLL_LEVEL(STRAP_PLL_LEVEL),
    .PLL_LEVEL(PLL_LEVEL));

// [testbench.sv]
/* Self-checking bench for ssl_regs, driven as an APB master.
   Assumes the slave answers each access, with or without wait states. */
`timescale 1ns/1ps
module testbench;
    import ssl_pkg::*;
    logic        CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, er;
    logic [7:0]  PADDR = '0;
    logic [31:0] PWDATA = '0, PRDATA, rd, wd, pd;
    logic [3:0]  PSTRB = '0;
    logic        PREADY, PSLVERR;
    ssl_supply_t SUPPLY = '0;
    logic [6:0]  STRAP_CORE_LEVEL = 7'h44, CORE_LEVEL, cc;
    logic [2:0]  STRAP_PLL_LEVEL = 3'h2, PLL_LEVEL, pc;
    int          err_count = 0, num_checks = 0, seed = 74;
    ssl_regs ssl_regs_i (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SUPPLY(SUPPLY),
        .STRAP_CORE_LEVEL(STRAP_CORE_LEVEL), .STRAP_PLL_LEVEL(STRAP_PLL_LEVEL),
        .CORE_LEVEL(CORE_LEVEL), .PLL_LEVEL(PLL_LEVEL));
    always #5 CLK = ~CLK;
    // ----------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------
    function automatic logic [31:0] st_exp(input ssl_supply_t s);
        return {7'h0, s[6], 4'h0, s[5], 2'h0, s[4],
                6'h0, s[3:2], 6'h0, s[1:0]};
    endfunction
    function automatic logic [6:0] clamp(input logic [6:0] c);
        return (c > 7'h46) ? 7'h46 : c;
    endfunction
    task automatic chk(input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        PSTRB <= s;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK);
        end while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic results;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        results();
    end
    // ----------------------------------------------------------
    // Two resets, each followed by stepped level traffic
    // ----------------------------------------------------------
    initial begin
        for (int r = 0; r < 2; r++) begin
            RST <= 1'b1;
            STRAP_CORE_LEVEL <= r ? 7'h0a : 7'h44;
            STRAP_PLL_LEVEL <= r ? 3'h6 : 3'h2;
            repeat (6) @(posedge CLK);
            RST <= 1'b0;
            cc = STRAP_CORE_LEVEL;
            pc = STRAP_PLL_LEVEL;
            apb(1'b0, 8'h34, '0, 4'h0);
            chk(rd, {25'h0, cc});
            apb(1'b0, 8'h40, '0, 4'h0);
            chk(rd, {29'h0, pc});
            for (int i = 0; i < 12; i++) begin
                SUPPLY <= (i < 7) ? 7'h01 << i : 7'($random(seed));
                repeat (100) @(posedge CLK);
                apb(1'b0, 8'h30, '0, 4'h0);
                chk(rd, st_exp(SUPPLY));
                chk({31'h0, er}, 32'h0);
                wd = $random(seed);
                // One code per microsecond, mostly upward to reach the top
                wd[6:0] = ($random(seed) % 4 != 0) ?
                          cc + 7'h01 : cc - 7'h01;
                cc = clamp(wd[6:0]);
                apb(1'b1, 8'h34, wd, 4'h1);
                apb(1'b0, 8'h34, '0, 4'h0);
                chk(rd, {25'h0, cc});
                chk({25'h0, CORE_LEVEL}, {25'h0, cc});
                pd = $random(seed);
                if (pd[2:0] > pc) pd[2:0] = pc + 3'h1;
                pc = pd[2:0];
                apb(1'b1, 8'h40, pd, 4'hf);
                apb(1'b0, 8'h40, '0, 4'h0);
                chk(rd, {29'h0, pc});
                chk({29'h0, PLL_LEVEL}, {29'h0, pc});
                apb(1'b1, 8'h30, wd, 4'hf);
                apb(1'b1, 8'h34, ~wd, 4'he);
                apb(1'b0, 8'h34, '0, 4'h0);
                chk(rd, {25'h0, cc});
                apb(1'b0, 8'h44 + i[7:0], '0, 4'h0);
                chk(rd, 32'h0000_0000);
                chk({31'h0, er}, 32'h0000_0001);
            end
        end
        results();
    end
endmodule
